// *** hw/stcpcr_pkg.sv ***
/*
 * stcpcr_pkg: register map, field layout, reset values and timing
 * constants for the system time readout and absolute time compare block.
 * Assumes a single 10 MHz clock and an APB register bus with 32-bit data.
 */
package stcpcr_pkg;
    // byte offsets (chosen for this block)
    localparam logic [7:0] OFF_UPPER    = 8'h00;
    localparam logic [7:0] OFF_LOWER    = 8'h04;
    localparam logic [7:0] OFF_CMP_LOW  = 8'h08;
    localparam logic [7:0] OFF_CMP_HIGH = 8'h0c;
    localparam logic [7:0] OFF_MSK_LOW  = 8'h10;
    localparam logic [7:0] OFF_MSK_HIGH = 8'h14;
    localparam logic [7:0] OFF_CTRL     = 8'h18;
    localparam logic [7:0] OFF_STATUS   = 8'h1c;
    localparam logic [7:0] OFF_IMASK    = 8'h20;

    // upper time register fields
    localparam int UPPER_TOP_BIT = 0;
    localparam int UPPER_EXT_LSB = 1;
    localparam int EXT_W         = 9;
    // control register fields
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_MODE_BIT = 1;
    // status / interrupt mask fields
    localparam int STAT_CMP_BIT  = 0;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // timing: extension counts 0..299 per base tick (27 MHz / 300 = 90 kHz)
    localparam int STC_HZ       = 27_000_000;
    localparam int BASE_HZ      = 90_000;
    localparam logic [8:0] EXT_LAST = 9'h12b;

    // the 33-bit time value as it travels through the block
    typedef struct packed {
        logic        top;
        logic [31:0] low;
    } stcpcr_time_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } stcpcr_apb_req_t;
endpackage

// *** hw/stcpcr_top.sv ***
/*
 * stcpcr_top: system time counter (33-bit base plus 9-bit extension),
 * upper/lower readout, masked 33-bit absolute time compare, sticky
 * interrupt status with mask, all behind an APB slave.
 * Assumes i_stc_tick is one-cycle pulse per 27 MHz time clock tick,
 * synchronous to i_clk; the counter advances once per pulse while transport mode (CTRL_MODE_BIT) is set.
 */
// Behaviour
// - extension count in upper bits 9..1
// - base count top bit in upper bit 0
// - upper bits 31..10 read zero, ignore writes
// - writable 32-bit low compare word
// - masked match with enable sets compare flag; code also requires transport mode (CTRL_MODE_BIT set)
// - compare raises interrupt at chosen time
// - base count at 90 kHz, low word separate
// - extension changes at time clock rate
// - high compare register holds top bit
// - mask bit one excludes that bit
`timescale 1ns/10ps
`default_nettype none
module stcpcr_top
    import stcpcr_pkg::*;
#(
    parameter int EXT_WIDTH = 9
) (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_stc_tick,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_irq
);
    // the extension field is fixed in the register layout
    if (EXT_WIDTH != EXT_W) begin : g_chk
        $error("EXT_WIDTH must equal the register field width");
    end

    stcpcr_apb_req_t req;
    logic            wr_acc;
    logic            rd_acc;
    logic            addr_ok;

    logic [8:0]   ext_q;
    stcpcr_time_t base_q;
    stcpcr_time_t cmp_q;
    stcpcr_time_t msk_q;
    logic         en_q;
    logic         tsmode_q;
    logic         stat_q;
    logic         imask_q;
    logic         hit_now;
    logic         hit_q;
    logic         cmp_evt;
    logic [31:0]  rd_d;

    assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                   paddr: i_paddr, pwdata: i_pwdata};

    // access phase; answer lands one cycle later, so pready waits
    assign wr_acc = req.psel && req.penable && req.pwrite && o_pready;
    assign rd_acc = req.psel && req.penable && !req.pwrite && o_pready;

    // pready rises on the second access cycle: one wait state per transfer
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= req.psel && req.penable && !o_pready;
        end
    end

    always_comb begin
        case (req.paddr)
            OFF_UPPER, OFF_LOWER, OFF_CMP_LOW, OFF_CMP_HIGH, OFF_MSK_LOW,
            OFF_MSK_HIGH, OFF_CTRL, OFF_STATUS, OFF_IMASK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // time counter: extension wraps at 299, then base steps
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ext_q  <= 9'h000;
            base_q <= '0;
        end else if (tsmode_q && i_stc_tick) begin
            if (ext_q == EXT_LAST) begin
                ext_q  <= 9'h000;
                base_q <= base_q + 33'h1;
            end else begin
                ext_q <= ext_q + 9'h001;
            end
        end
    end

    // software-written compare, mask and control
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmp_q    <= '0;
            msk_q    <= '0;
            en_q     <= 1'b0;
            tsmode_q <= 1'b0;
            imask_q  <= 1'b0;
        end else if (wr_acc) begin
            case (req.paddr)
                OFF_CMP_LOW:  cmp_q.low <= req.pwdata;
                OFF_CMP_HIGH: cmp_q.top <= req.pwdata[0];
                OFF_MSK_LOW:  msk_q.low <= req.pwdata;
                OFF_MSK_HIGH: msk_q.top <= req.pwdata[0];
                OFF_CTRL: begin
                    en_q     <= req.pwdata[CTRL_EN_BIT];
                    tsmode_q <= req.pwdata[CTRL_MODE_BIT];
                end
                OFF_IMASK: imask_q <= req.pwdata[STAT_CMP_BIT];
                default: ;
            endcase
        end
    end

    // masked equality; edge-detected so one match gives one event.
    // a half-written compare can match falsely unless enable is off
    assign hit_now = en_q && tsmode_q &&
        ((((base_q ^ cmp_q) & ~msk_q)) == 33'h0);
    assign cmp_evt = hit_now && !hit_q;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= hit_now;
        end
    end

    // sticky flag, write one to clear; a new event beats the clear
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            stat_q <= 1'b0;
        end else if (cmp_evt) begin
            stat_q <= 1'b1;
        end else if (wr_acc && req.paddr == OFF_STATUS &&
                     req.pwdata[STAT_CMP_BIT]) begin
            stat_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= (stat_q || cmp_evt) && imask_q;
        end
    end

    // read mux; unused bits stay zero
    always_comb begin
        rd_d = RST_WORD;
        case (req.paddr)
            OFF_UPPER: begin
                rd_d[UPPER_TOP_BIT] = base_q.top;
                rd_d[UPPER_EXT_LSB +: EXT_W] = ext_q;
            end
            OFF_LOWER:    rd_d = base_q.low;
            OFF_CMP_LOW:  rd_d = cmp_q.low;
            OFF_CMP_HIGH: rd_d[0] = cmp_q.top;
            OFF_MSK_LOW:  rd_d = msk_q.low;
            OFF_MSK_HIGH: rd_d[0] = msk_q.top;
            OFF_CTRL: begin
                rd_d[CTRL_EN_BIT]   = en_q;
                rd_d[CTRL_MODE_BIT] = tsmode_q;
            end
            OFF_STATUS: rd_d[STAT_CMP_BIT] = stat_q;
            OFF_IMASK:  rd_d[STAT_CMP_BIT] = imask_q;
            default: rd_d = RST_WORD;
        endcase
    end

    // read data and error registered with the wait state
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_prdata  <= RST_WORD;
            o_pslverr <= 1'b0;
        end else begin
            o_prdata  <= (req.psel && req.penable && !req.pwrite) ? rd_d
                                                                 : RST_WORD;
            o_pslverr <= req.psel && req.penable && !o_pready && !addr_ok;
        end
    end

    // checks
    property p_flag_set;
        @(posedge i_clk) disable iff (!i_rstn)
        cmp_evt |=> stat_q;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set");

    property p_no_hit_dis;
        @(posedge i_clk) disable iff (!i_rstn)
        !en_q |-> !hit_now;
    endproperty
    a_no_hit_dis: assert property (p_no_hit_dis)
        else $error("hit off");

    property p_irq;
        @(posedge i_clk) disable iff (!i_rstn)
        (stat_q && imask_q) |=> o_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq missing");

    property p_mode_idle;
        @(posedge i_clk) disable iff (!i_rstn)
        !tsmode_q |=> $stable(base_q) && $stable(ext_q);
    endproperty
    a_mode_idle: assert property (p_mode_idle)
        else $error("count moved");

    property p_ext_range;
        @(posedge i_clk) disable iff (!i_rstn)
        ext_q <= EXT_LAST;
    endproperty
    a_ext_range: assert property (p_ext_range)
        else $error("ext range");

    property p_base_step;
        @(posedge i_clk) disable iff (!i_rstn)
        (tsmode_q && i_stc_tick && ext_q == EXT_LAST) |=>
            base_q == $past(base_q) + 33'h1 && ext_q == 9'h000;
    endproperty
    a_base_step: assert property (p_base_step)
        else $error("base step");

    property p_upper_read;
        @(posedge i_clk) disable iff (!i_rstn)
        (rd_acc && req.paddr == OFF_UPPER) |-> o_prdata[31:10] == 22'h0;
    endproperty
    a_upper_read: assert property (p_upper_read)
        else $error("upper bits");

    property p_cmp_wr;
        @(posedge i_clk) disable iff (!i_rstn)
        (wr_acc && req.paddr == OFF_CMP_LOW) |=>
            cmp_q.low == $past(req.pwdata);
    endproperty
    a_cmp_wr: assert property (p_cmp_wr)
        else $error("cmp write");

    property p_mask_all;
        @(posedge i_clk) disable iff (!i_rstn)
        (en_q && tsmode_q && &msk_q) |-> hit_now;
    endproperty
    a_mask_all: assert property (p_mask_all)
        else $error("mask");

    // status flag: write one clears it only when no new event competes
    property p_flag_clear;
        @(posedge i_clk) disable iff (!i_rstn)
        (!cmp_evt && wr_acc && req.paddr == OFF_STATUS &&
         req.pwdata[STAT_CMP_BIT]) |=> !stat_q;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag not cleared");

    // sticky: without a status write the flag never drops on its own
    property p_flag_hold;
        @(posedge i_clk) disable iff (!i_rstn)
        (stat_q && !(wr_acc && req.paddr == OFF_STATUS)) |=> stat_q;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag dropped");

    // a masked-off interrupt stays quiet whatever the flag does
    property p_irq_off;
        @(posedge i_clk) disable iff (!i_rstn)
        !imask_q |=> !o_irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("irq while masked");

    // bus answer: exactly one wait state, ready lasts a single cycle
    property p_ready_wait;
        @(posedge i_clk) disable iff (!i_rstn)
        (req.psel && req.penable && !o_pready) |=> o_pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("ready late");

    property p_ready_pulse;
        @(posedge i_clk) disable iff (!i_rstn)
        o_pready |=> !o_pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held");

    // an error is only ever reported together with ready
    property p_err_ready;
        @(posedge i_clk) disable iff (!i_rstn)
        o_pslverr |-> o_pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error without ready");

    // extension advances by one per tick below its last value
    property p_ext_step;
        @(posedge i_clk) disable iff (!i_rstn)
        (tsmode_q && i_stc_tick && ext_q != EXT_LAST) |=>
            ext_q == $past(ext_q) + 9'h001;
    endproperty
    a_ext_step: assert property (p_ext_step)
        else $error("ext step");

    // only bit 0 of the high compare word is kept
    property p_cmp_high_wr;
        @(posedge i_clk) disable iff (!i_rstn)
        (wr_acc && req.paddr == OFF_CMP_HIGH) |=>
            cmp_q.top == $past(req.pwdata[0]);
    endproperty
    a_cmp_high_wr: assert property (p_cmp_high_wr)
        else $error("cmp high write");

    // outside transport mode the compare never fires
    property p_mode_no_evt;
        @(posedge i_clk) disable iff (!i_rstn)
        !tsmode_q |-> !cmp_evt;
    endproperty
    a_mode_no_evt: assert property (p_mode_no_evt)
        else $error("event outside mode");

    // scenarios worth seeing: a clear, and a match through the mask
    c_clear: cover property (@(posedge i_clk) disable iff (!i_rstn)
        stat_q ##1 !stat_q);
    c_masked: cover property (@(posedge i_clk) disable iff (!i_rstn)
        cmp_evt && (msk_q != '0));

    c_evt:   cover property (@(posedge i_clk) disable iff (!i_rstn) cmp_evt);
    c_irq:   cover property (@(posedge i_clk) disable iff (!i_rstn) o_irq);
    c_wrap:  cover property (@(posedge i_clk) disable iff (!i_rstn)
        tsmode_q && i_stc_tick && ext_q == EXT_LAST);
endmodule
`default_nettype wire

// *** verif/stcpcr_tb.sv ***
/*
 * testbench for stcpcr_top: apb register access, time counter readout,
 * masked absolute compare, sticky status and interrupt output.
 * assumes the design package and one 10 MHz clock; ticks are driven here.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
    failures++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module testbench;
    import stcpcr_pkg::*;
    localparam int EXT_MOD = int'(EXT_LAST) + 1;
    logic        clk;
    logic        rstn;
    logic        tick;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] r;
    logic        e;
    int          failures = 0;
    int          tests_run = 0;
    int          nt = 0;
    int          v;
    int          t0;

    stcpcr_top dut_u (.i_clk(clk), .i_rstn(rstn), .i_stc_tick(tick),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq));

    // free-running 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // one apb transfer; waits for pready under a bound, never a fixed count
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        y;
        apb(1'b1, a, d, x, y);
    endtask

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] ex);
        logic [31:0] x;
        logic        y;
        apb(1'b0, a, 32'h0, x, y);
        `CHK(nm, ex, x)
    endtask

    // spaced pulses: a tick every other cycle keeps each pulse one cycle
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
        nt += n;
    endtask

    // expected upper word from the total ticks counted by the bench
    function automatic logic [31:0] up_exp(input int n);
        return {22'h0, 9'(n % EXT_MOD), 1'b0};
    endfunction

    task automatic print_verdict;
        if (failures == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // watchdog well beyond the few thousand cycles the tests need
    initial begin
        #(40000 * 100);
        failures++;
        print_verdict();
    end

    initial begin
        rstn = 1'b0;
        tick = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(79));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i <= 8; i++) rd("reset", 8'(i * 4), RST_WORD);
        apb(1'b0, 8'h24, 32'h0, r, e);
        `CHK("unmapped", 1'b1, e)
        // out of transport mode ticks must not move the count
        ticks(5);
        nt = 0;
        rd("idle", OFF_LOWER, 32'h0);
        wr(OFF_UPPER, 32'hffff_ffff);
        rd("upper ro", OFF_UPPER, 32'h0);
        pwdata <= 32'h0;
        r = $urandom;
        wr(OFF_CMP_LOW, r);
        rd("cmp low", OFF_CMP_LOW, r);
        wr(OFF_CMP_HIGH, 32'hffff_ffff);
        rd("cmp high", OFF_CMP_HIGH, 32'h1);
        wr(OFF_CMP_HIGH, 32'h0);
        wr(OFF_IMASK, 32'h1);
        wr(OFF_CTRL, 32'h2);
        ticks(EXT_MOD * $urandom_range(1, 3) + $urandom_range(0, EXT_LAST));
        rd("upper", OFF_UPPER, up_exp(nt));
        rd("lower", OFF_LOWER, 32'(nt / EXT_MOD));
        // match passes while compare is disabled: no flag
        wr(OFF_CMP_LOW, 32'(nt / EXT_MOD + 1));
        ticks(EXT_MOD);
        rd("no enable", OFF_STATUS, 32'h0);
        wr(OFF_CMP_LOW, 32'(nt / EXT_MOD + 1));
        wr(OFF_CTRL, 32'h3);
        rd("before", OFF_STATUS, 32'h0);
        ticks(EXT_MOD);
        rd("match", OFF_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("irq on", 1'b1, irq)
        wr(OFF_IMASK, 32'h0);
        repeat (2) @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        wr(OFF_IMASK, 32'h1);
        wr(OFF_STATUS, 32'h1);
        rd("cleared", OFF_STATUS, 32'h0);
        `CHK("irq off", 1'b0, irq)
        // only the mask of bit 0 lets the even base reach the odd target
        v = nt / EXT_MOD;
        t0 = (v + 2) & ~1;
        wr(OFF_CTRL, 32'h2);
        wr(OFF_CMP_LOW, 32'(t0 | 1));
        wr(OFF_MSK_LOW, 32'h1);
        wr(OFF_CTRL, 32'h3);
        ticks((t0 - v) * EXT_MOD);
        rd("masked", OFF_STATUS, 32'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
